/* hdl/bpp_params.svh */
// constants for the two bidirectional ports and their register map
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
`ifndef BPP_PARAMS_SVH
`define BPP_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define BPP_OFS_C_PINS 4'h0
`define BPP_OFS_C_LATCH 4'h4
`define BPP_OFS_C_DIR 4'h8
`define BPP_OFS_D_PINS 4'hc
`define BPP_ADDR_W 6
`define BPP_OFS2_D_LATCH 6'h10
`define BPP_OFS2_D_DIR 6'h14
`define BPP_OFS2_E_DIR 6'h18
`define BPP_OFS2_PERIPH 6'h1c

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define BPP_DIR_RST 8'hff
`define BPP_LATCH_RST 8'h00
`define BPP_E_DIR_RST 8'h07
`define BPP_PSP_BIT 4
`define BPP_BIT_SCL 3
`define BPP_BIT_SDA 4
`define BPP_BIT_SDO 5
`define BPP_BIT_TX 6
`define BPP_BIT_RX 7
`define BPP_BIT_PB 5
`define BPP_BIT_PC 6
`define BPP_BIT_PD 7
// periph register fields
`define BPP_F_I2C 0
`define BPP_F_SPI 1
`define BPP_F_UART 2
`define BPP_F_SYNC 3
`define BPP_F_PWM_MULTI 4
`define BPP_F_PSP_OFF 8
`define BPP_F_PIN_TTL 9

`endif

/* hdl/bpp_pkg.sv */
// types shared by the port block
// assumes the params header is included by users of the widths
package bpp_pkg;

    typedef enum logic [1:0] {
        BPP_IDLE = 2'b01,
        BPP_ACK = 2'b10
    } bpp_bus_state_t;

    typedef struct packed {
        bpp_bus_state_t st;
        logic [31:0] rdata;
    } bpp_bus_t;

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
    } bpp_sync_t;

endpackage

/* hdl/bpp_pin_sync.sv */
// two-stage synchroniser for an 8-bit group of pad inputs
// assumes pads are asynchronous to core_clk
`timescale 1ns/10ps
module bpp_pin_sync (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_sync
);

    bpp_pkg::bpp_sync_t state;
    bpp_pkg::bpp_sync_t next_state;

    // first stage feeds only the second
    always_comb begin
        next_state = state;
        next_state.sync1 = pad_in;
        next_state.sync2 = state.sync1;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pad_sync = state.sync2;

endmodule

/* hdl/bpp_port_top.sv */
// port c and second port with latch, direction and peripheral overrides
// assumes an avalon-mm master on core_clk and pads resolved outside
`timescale 1ns/10ps
`include "bpp_params.svh"
module bpp_port_top (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] pc_pad_in,
    output logic [7:0] pc_pad_out,
    output logic [7:0] pc_pad_oe,
    input wire logic [7:0] pd_pad_in,
    output logic [7:0] pd_pad_out,
    output logic [7:0] pd_pad_oe,
    output logic pd_ttl_buffers,
    input wire logic i2c_scl_out,
    input wire logic i2c_sda_out,
    output logic i2c_scl_in,
    output logic i2c_sda_in,
    input wire logic spi_serial_out,
    output logic spi_serial_in,
    input wire logic usart_tx_out,
    input wire logic usart_sync_clock_out,
    input wire logic usart_sync_data_out,
    output logic usart_sync_clock_in,
    output logic usart_rx_in,
    input wire logic pwm_channel_b,
    input wire logic pwm_channel_c,
    input wire logic pwm_channel_d,
    input wire logic pwm_channel_b_tri,
    input wire logic pwm_channel_c_tri,
    input wire logic pwm_channel_d_tri,
    output logic parallel_slave_active,
    input wire logic psp_read_drive
);

    typedef struct packed {
        bpp_pkg::bpp_bus_t bus;
        logic [7:0] port_c_output_latch;
        logic [7:0] port_c_direction;
        logic [7:0] second_port_output_latch;
        logic [7:0] second_port_direction;
        logic [7:0] port_e_direction;
        logic [4:0] periph_sel;
        logic [7:0] pc_out;
        logic [7:0] pc_oe;
        logic [7:0] pd_out;
        logic [7:0] pd_oe;
    } bpp_state_t;

    bpp_state_t state;
    bpp_state_t next_state;
    logic [7:0] pc_sync;
    logic [7:0] pd_sync;
    logic i2c_on;
    logic spi_on;
    logic uart_on;
    logic sync_mode;
    logic pwm_multi;
    logic psp_on;

    // ---------------------------------------------------------------
    // pad synchronisers
    // ---------------------------------------------------------------
    bpp_pin_sync u_sync_c (
        .core_clk(core_clk),
        .srst(srst),
        .pad_in(pc_pad_in),
        .pad_sync(pc_sync)
    );

    bpp_pin_sync u_sync_d (
        .core_clk(core_clk),
        .srst(srst),
        .pad_in(pd_pad_in),
        .pad_sync(pd_sync)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // byte-lane write merge; only lane 0 carries the 8-bit registers
    function automatic logic [7:0] bpp_merge(input logic [7:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        bpp_merge = be[0] ? wd[7:0] : old;
    endfunction

    // ---------------------------------------------------------------
    // decoded peripheral enables
    // ---------------------------------------------------------------
    assign i2c_on = state.periph_sel[`BPP_F_I2C];
    assign spi_on = state.periph_sel[`BPP_F_SPI];
    assign uart_on = state.periph_sel[`BPP_F_UART];
    assign sync_mode = state.periph_sel[`BPP_F_SYNC];
    assign pwm_multi = state.periph_sel[`BPP_F_PWM_MULTI];
    // pwm with dual or quad outputs wins over the slave port
    assign psp_on = state.port_e_direction[`BPP_PSP_BIT] & ~pwm_multi;

    // ---------------------------------------------------------------
    // next state: bus slave, registers, pin muxes
    // ---------------------------------------------------------------
    always_comb begin
        logic [7:0] c_out;
        logic [7:0] c_oe;
        logic [7:0] d_out;
        logic [7:0] d_oe;
        logic [5:0] a;
        next_state = state;
        a = avs_address;
        // default port behaviour per pin
        c_out = state.port_c_output_latch;
        c_oe = ~state.port_c_direction;
        d_out = state.second_port_output_latch;
        d_oe = ~state.second_port_direction;

        // i2c drives only with direction 0, open-drain handled by module
        if (i2c_on) begin
            c_out[`BPP_BIT_SCL] = i2c_scl_out;
            c_out[`BPP_BIT_SDA] = i2c_sda_out;
        end
        // spi output at bit 5 when direction is 0
        if (spi_on) begin
            c_out[`BPP_BIT_SDO] = spi_serial_out;
        end
        if (uart_on) begin
            if (sync_mode) begin
                c_out[`BPP_BIT_TX] = usart_sync_clock_out;
                c_out[`BPP_BIT_RX] = usart_sync_data_out;
            end else begin
                c_out[`BPP_BIT_TX] = usart_tx_out;
            end
        end

        // slave port: direction bits do not matter, port drives on read
        if (psp_on) begin
            d_out = state.second_port_output_latch;
            d_oe = {8{psp_read_drive}};
        end
        // pwm pins override port and slave data, tri-state on shutdown
        if (pwm_multi) begin
            d_out[`BPP_BIT_PB] = pwm_channel_b;
            d_out[`BPP_BIT_PC] = pwm_channel_c;
            d_out[`BPP_BIT_PD] = pwm_channel_d;
            d_oe[`BPP_BIT_PB] = ~state.second_port_direction[`BPP_BIT_PB] & ~pwm_channel_b_tri;
            d_oe[`BPP_BIT_PC] = ~state.second_port_direction[`BPP_BIT_PC] & ~pwm_channel_c_tri;
            d_oe[`BPP_BIT_PD] = ~state.second_port_direction[`BPP_BIT_PD] & ~pwm_channel_d_tri;
        end
        next_state.pc_out = c_out;
        next_state.pc_oe = c_oe;
        next_state.pd_out = d_out;
        next_state.pd_oe = d_oe;

        // one wait cycle per access, answer in the ack cycle
        case (state.bus.st)
            bpp_pkg::BPP_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state.bus.st = bpp_pkg::BPP_ACK;
                    next_state.bus.rdata = '0;
                    if (avs_read) begin
                        case (a)
                            {2'b00, `BPP_OFS_C_PINS}: next_state.bus.rdata[7:0] = pc_sync;
                            {2'b00, `BPP_OFS_C_LATCH}: begin
                                next_state.bus.rdata[7:0] = state.port_c_output_latch;
                            end
                            {2'b00, `BPP_OFS_C_DIR}: begin
                                next_state.bus.rdata[7:0] = state.port_c_direction;
                            end
                            {2'b00, `BPP_OFS_D_PINS}: next_state.bus.rdata[7:0] = pd_sync;
                            `BPP_OFS2_D_LATCH: begin
                                next_state.bus.rdata[7:0] = state.second_port_output_latch;
                            end
                            `BPP_OFS2_D_DIR: begin
                                next_state.bus.rdata[7:0] = state.second_port_direction;
                            end
                            `BPP_OFS2_E_DIR: next_state.bus.rdata[7:0] = state.port_e_direction;
                            `BPP_OFS2_PERIPH: begin
                                next_state.bus.rdata[4:0] = state.periph_sel;
                                next_state.bus.rdata[`BPP_F_PSP_OFF] = pwm_multi;
                                next_state.bus.rdata[`BPP_F_PIN_TTL] = psp_on;
                            end
                            default: next_state.bus.rdata = '0;
                        endcase
                    end else begin
                        // writes to pins and latch both land in the latch
                        case (a)
                            {2'b00, `BPP_OFS_C_PINS}, {2'b00, `BPP_OFS_C_LATCH}: begin
                                next_state.port_c_output_latch = bpp_merge(
                                    state.port_c_output_latch, avs_writedata,
                                    avs_byteenable);
                            end
                            {2'b00, `BPP_OFS_C_DIR}: begin
                                next_state.port_c_direction = bpp_merge(
                                    state.port_c_direction, avs_writedata, avs_byteenable);
                            end
                            {2'b00, `BPP_OFS_D_PINS}, `BPP_OFS2_D_LATCH: begin
                                next_state.second_port_output_latch = bpp_merge(
                                    state.second_port_output_latch, avs_writedata,
                                    avs_byteenable);
                            end
                            `BPP_OFS2_D_DIR: begin
                                next_state.second_port_direction = bpp_merge(
                                    state.second_port_direction, avs_writedata,
                                    avs_byteenable);
                            end
                            `BPP_OFS2_E_DIR: begin
                                next_state.port_e_direction = bpp_merge(
                                    state.port_e_direction, avs_writedata,
                                    avs_byteenable);
                            end
                            `BPP_OFS2_PERIPH: begin
                                if (avs_byteenable[0]) begin
                                    next_state.periph_sel = avs_writedata[4:0];
                                end
                            end
                            default: next_state.periph_sel = state.periph_sel;
                        endcase
                    end
                end
            end
            bpp_pkg::BPP_ACK: begin
                next_state.bus.st = bpp_pkg::BPP_IDLE;
            end
            default: begin
                next_state.bus.st = bpp_pkg::BPP_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state.bus.st <= bpp_pkg::BPP_IDLE;
            state.bus.rdata <= '0;
            state.port_c_output_latch <= `BPP_LATCH_RST;
            state.port_c_direction <= `BPP_DIR_RST;
            state.second_port_output_latch <= `BPP_LATCH_RST;
            state.second_port_direction <= `BPP_DIR_RST;
            state.port_e_direction <= `BPP_E_DIR_RST;
            state.periph_sel <= '0;
            state.pc_out <= '0;
            state.pc_oe <= '0;
            state.pd_out <= '0;
            state.pd_oe <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // waitrequest falls only in the ack cycle
    assign avs_waitrequest = (avs_read | avs_write) & (state.bus.st != bpp_pkg::BPP_ACK);
    assign avs_readdata = state.bus.rdata;
    assign pc_pad_out = state.pc_out;
    assign pc_pad_oe = state.pc_oe;
    assign pd_pad_out = state.pd_out;
    assign pd_pad_oe = state.pd_oe;
    assign pd_ttl_buffers = psp_on;
    assign parallel_slave_active = psp_on;
    // peripheral inputs come from synchronised pins when not driven
    assign i2c_scl_in = pc_sync[`BPP_BIT_SCL];
    assign i2c_sda_in = pc_sync[`BPP_BIT_SDA];
    assign spi_serial_in = pc_sync[`BPP_BIT_SDA];
    assign usart_sync_clock_in = pc_sync[`BPP_BIT_TX];
    assign usart_rx_in = pc_sync[`BPP_BIT_RX];

endmodule

/* verification/bpp_pin_model.sv */
// pad resolver standing for the board outside port c or the second port
// assumes one instance per port, fed by the top's pad outputs
`timescale 1ns/10ps
module bpp_pin_model (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pad_in
);
    // a driven pin shows the block's value, an input pin the board's level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

/* verification/bpp_port_checker.sv */
// concurrent checks on the port block's top-level pins
// assumes one core_clk domain and srst synchronous, active high
`timescale 1ns/10ps
module bpp_port_checker (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] pc_pad_in,
    input wire logic [7:0] pc_pad_oe,
    input wire logic [7:0] pd_pad_oe,
    input wire logic pd_ttl_buffers,
    input wire logic i2c_scl_in,
    input wire logic i2c_sda_in,
    input wire logic spi_serial_in,
    input wire logic usart_sync_clock_in,
    input wire logic usart_rx_in,
    input wire logic parallel_slave_active,
    input wire logic psp_read_drive
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // peripheral inputs lag the pad by the two synchroniser stages
    a_scl_in_path: assert property (!$past(srst) && !$past(srst, 2) |->
        i2c_scl_in == $past(pc_pad_in[3], 2)) else $error("scl input path wrong");
    a_sda_spi_path: assert property (!$past(srst) && !$past(srst, 2) |->
        i2c_sda_in == $past(pc_pad_in[4], 2) && spi_serial_in == $past(pc_pad_in[4], 2))
        else $error("sda or spi input path wrong");
    a_rx_in_path: assert property (!$past(srst) && !$past(srst, 2) |->
        usart_rx_in == $past(pc_pad_in[7], 2)) else $error("rx input path wrong");
    a_ck_in_path: assert property (!$past(srst) && !$past(srst, 2) |->
        usart_sync_clock_in == $past(pc_pad_in[6], 2)) else $error("sync clock input wrong");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("access not answered after one wait state");
    // every pin must come out of reset undriven
    a_oe_reset: assert property ($past(srst) |->
        pc_pad_oe == 8'h00 && pd_pad_oe == 8'h00) else $error("pad driven after reset");
    a_slave_ttl: assert property (pd_ttl_buffers == parallel_slave_active)
        else $error("ttl buffers not tied to slave mode");
    a_slave_drive: assert property (!$past(srst) && $past(parallel_slave_active) |->
        pd_pad_oe == {8{$past(psp_read_drive)}}) else $error("slave port drive wrong");
    a_rdata_narrow: assert property (avs_read && !avs_waitrequest &&
        avs_address != 6'h1c |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");

    c_write: cover property (avs_write && !avs_waitrequest);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_slave: cover property (parallel_slave_active && psp_read_drive);
endmodule

/* verification/bpp_port_top_tb.sv */
// self-checking bench for the two-port block with peripheral overrides
// assumes the design files and the pin model and checker are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module bpp_port_top_tb;
    logic core_clk, srst, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] pc_pad_in, pc_pad_out, pc_pad_oe, pd_pad_in, pd_pad_out, pd_pad_oe;
    logic [7:0] ext_c, ext_d;
    logic pd_ttl_buffers, i2c_scl_out, i2c_sda_out, i2c_scl_in, i2c_sda_in;
    logic spi_serial_out, spi_serial_in, usart_tx_out, usart_sync_clock_out;
    logic usart_sync_data_out, usart_sync_clock_in, usart_rx_in;
    logic pwm_channel_b, pwm_channel_c, pwm_channel_d;
    logic pwm_channel_b_tri, pwm_channel_c_tri, pwm_channel_d_tri;
    logic parallel_slave_active, psp_read_drive;
    int err_total = 0;
    int n_checks = 0;

    bpp_port_top uut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pc_pad_in(pc_pad_in), .pc_pad_out(pc_pad_out),
        .pc_pad_oe(pc_pad_oe), .pd_pad_in(pd_pad_in), .pd_pad_out(pd_pad_out),
        .pd_pad_oe(pd_pad_oe), .pd_ttl_buffers(pd_ttl_buffers), .i2c_scl_out(i2c_scl_out),
        .i2c_sda_out(i2c_sda_out), .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in),
        .spi_serial_out(spi_serial_out), .spi_serial_in(spi_serial_in),
        .usart_tx_out(usart_tx_out), .usart_sync_clock_out(usart_sync_clock_out),
        .usart_sync_data_out(usart_sync_data_out), .usart_sync_clock_in(usart_sync_clock_in),
        .usart_rx_in(usart_rx_in), .pwm_channel_b(pwm_channel_b),
        .pwm_channel_c(pwm_channel_c), .pwm_channel_d(pwm_channel_d),
        .pwm_channel_b_tri(pwm_channel_b_tri), .pwm_channel_c_tri(pwm_channel_c_tri),
        .pwm_channel_d_tri(pwm_channel_d_tri), .parallel_slave_active(parallel_slave_active),
        .psp_read_drive(psp_read_drive));
    bpp_pin_model pins_c (.pad_out(pc_pad_out), .pad_oe(pc_pad_oe), .ext_level(ext_c),
        .pad_in(pc_pad_in));
    bpp_pin_model pins_d (.pad_out(pd_pad_out), .pad_oe(pd_pad_oe), .ext_level(ext_d),
        .pad_in(pd_pad_in));

    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic rw, input logic [5:0] a, input logic [7:0] d,
        output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        if (rw) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        // no local limit: only the watchdog may end a hung wait
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rd_chk(6'h08, 32'hff);
        rd_chk(6'h14, 32'hff);
        rd_chk(6'h04, 32'h00);
        rd_chk(6'h18, 32'h07);
        `CHK(pc_pad_oe | pd_pad_oe, 8'h00)
        wr(6'h24, 8'hff);
        rd_chk(6'h24, 32'h0);
        // a write with lane 0 off must leave the latch alone
        avs_byteenable <= 4'h0;
        wr(6'h04, 8'h33);
        avs_byteenable <= 4'hf;
        rd_chk(6'h04, 32'h00);
    endtask
    task automatic t_pins;
        wr(6'h00, 8'ha5);
        rd_chk(6'h04, 32'ha5);
        wr(6'h08, 8'hcf);
        ext_c <= 8'h3c;
        settle(4);
        `CHK(pc_pad_oe, 8'h30)
        `CHK(pc_pad_oe & 8'hcf, 8'h00)
        `CHK(pc_pad_out & 8'h30, 8'h20)
        rd_chk(6'h00, 32'h2c);
        rd_chk(6'h04, 32'ha5);
    endtask
    // latch is 0, so every 1 on a pad comes from a peripheral
    task automatic t_periph;
        wr(6'h08, 8'h00);
        wr(6'h04, 8'h00);
        {i2c_scl_out, i2c_sda_out, spi_serial_out, usart_tx_out} <= 4'hf;
        wr(6'h1c, 8'h07);
        settle(2);
        `CHK(pc_pad_out[3], 1'b1)
        `CHK(pc_pad_out[4], 1'b1)
        `CHK(pc_pad_out[5], 1'b1)
        `CHK(pc_pad_out[6], 1'b1)
        rd_chk(6'h08, 32'h00);
        {usart_sync_clock_out, usart_sync_data_out, usart_tx_out} <= 3'b110;
        wr(6'h1c, 8'h0c);
        settle(2);
        `CHK(pc_pad_out[6], 1'b1)
        `CHK(pc_pad_out[7], 1'b1)
        wr(6'h08, 8'hff);
        ext_c <= 8'hd0;
        settle(4);
        `CHK(i2c_scl_in, 1'b0)
        `CHK(i2c_sda_in, 1'b1)
        `CHK(spi_serial_in, 1'b1)
        `CHK(usart_sync_clock_in, 1'b1)
        `CHK(usart_rx_in, 1'b1)
    endtask
    task automatic t_second;
        wr(6'h10, 8'h5a);
        wr(6'h14, 8'h00);
        settle(2);
        `CHK(pd_pad_out, 8'h5a)
        `CHK(pd_pad_oe, 8'hff)
        wr(6'h14, 8'hff);
        psp_read_drive <= 1'b1;
        wr(6'h18, 8'h17);
        settle(2);
        `CHK(parallel_slave_active, 1'b1)
        `CHK(pd_pad_oe, 8'hff)
        `CHK(pd_ttl_buffers, 1'b1)
        rd_chk(6'h0c, 32'h5a);
        {pwm_channel_b, pwm_channel_c, pwm_channel_d} <= 3'b101;
        wr(6'h1c, 8'h10);
        settle(2);
        `CHK(parallel_slave_active, 1'b0)
        rd_chk(6'h1c, 32'h110);
        wr(6'h14, 8'h00);
        settle(2);
        `CHK(pd_pad_out[7:5], 3'b101)
        pwm_channel_b_tri <= 1'b1;
        settle(3);
        `CHK(pd_pad_oe[5], 1'b0)
    endtask
    // reset in mid-run puts every register back, first request right after release
    task automatic t_rerun;
        srst <= 1'b1;
        settle(3);
        srst <= 1'b0;
        `CHK(pd_pad_oe | pc_pad_oe, 8'h00)
        rd_chk(6'h14, 32'hff);
        rd_chk(6'h1c, 32'h0);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // free-running clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // a hang anywhere still reaches the verdict
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        stop_test();
    end
    // main sequence: reset, then each scenario in turn
    initial begin
        {srst, avs_read, avs_write, psp_read_drive} = 4'b1000;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        {ext_c, ext_d} = 16'h0;
        {i2c_scl_out, i2c_sda_out, spi_serial_out, usart_tx_out} = 4'h0;
        {usart_sync_clock_out, usart_sync_data_out} = 2'b00;
        {pwm_channel_b, pwm_channel_c, pwm_channel_d} = 3'b000;
        {pwm_channel_b_tri, pwm_channel_c_tri, pwm_channel_d_tri} = 3'b000;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_pins();
        t_periph();
        t_second();
        t_rerun();
        stop_test();
    end
endmodule

bind bpp_port_top bpp_port_checker chk (.core_clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .pc_pad_in, .pc_pad_oe, .pd_pad_oe,
    .pd_ttl_buffers, .i2c_scl_in, .i2c_sda_in, .spi_serial_in, .usart_sync_clock_in,
    .usart_rx_in, .parallel_slave_active, .psp_read_drive);
